/* design/run_mode_clock_gating_2.sv */
// Purpose: clock gating control bank with APB slave and fault status
// Assumes: one clock, units sit behind a decoded peripheral bus
// Notes: unit enables are registered; zero wait states on APB
//
// Implementation choice: the APB slave port.
`default_nettype none
module run_mode_clock_gating_2
  import clock_gate_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clock_gate_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire clock_gate_pkg::power_mode_type powerMode,
  input wire logic [clock_gate_pkg::UNIT_N-1:0] unitAccess,
  output logic [clock_gate_pkg::UNIT_N-1:0] unitClockOn,
  output logic [clock_gate_pkg::UNIT_N-1:0] unitDisable,
  output logic [clock_gate_pkg::UNIT_N-1:0] unitFault,
  output logic irq
);
  import clock_gate_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] runGate;
    logic [31:0] sleepGate;
    logic [31:0] deepGate;
    logic [31:0] runCfg;
    logic [31:0] irqStatus;
    logic [31:0] irqMask;
    logic [31:0] rdata;
    logic [UNIT_N-1:0] clockOn;
    logic [UNIT_N-1:0] fault;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [31:0] activeGate;
  logic [UNIT_N-1:0] activeOn;
  logic wrEn;
  logic rdEn;
  logic faultEvent;
  logic autoGate;
  logic [31:0] modeGate;
  logic setupCycle;
  logic accessCycle;
  logic runHit;
  logic sleepHit;
  logic deepHit;
  logic cfgHit;
  logic statusHit;
  logic maskHit;
  logic mappedHit;
  logic runWr;
  logic sleepWr;
  logic deepWr;
  logic cfgWr;
  logic statusWr;
  logic maskWr;
  logic [31:0] runGateWr;
  logic [31:0] sleepGateWr;
  logic [31:0] deepGateWr;
  logic [31:0] runCfgWr;
  logic [31:0] irqMaskWr;
  logic [31:0] statusClr;
  logic [31:0] statusSet;
  logic [31:0] readMux;
  logic [UNIT_N-1:0] faultVec;
  logic irqPending;

  // ****************************************
  // Mode selection
  // ****************************************
  // Auto gating bit lets the power mode pick the bank
  assign autoGate = state_q.runCfg[BIT_AUTO_GATE];

  always_comb begin
    modeGate = state_q.runGate;
    case (powerMode)
      MODE_RUN: begin
        modeGate = state_q.runGate;
      end
      MODE_SLEEP: begin
        modeGate = state_q.sleepGate;
      end
      MODE_DEEP: begin
        modeGate = state_q.deepGate;
      end
      default: begin
        modeGate = state_q.runGate;
      end
    endcase
  end

  // Without auto gating the run bank stays in force
  always_comb begin
    activeGate = state_q.runGate;
    if (autoGate) begin
      activeGate = modeGate;
    end
  end

  unit_gate_map u_map (
    .gateWord(activeGate),
    .unitOn(activeOn)
  );

  // ****************************************
  // Bus phase and address decode
  // ****************************************
  // Setup cycle latches read data, access cycle commits writes
  assign setupCycle = psel && !penable;
  assign accessCycle = psel && penable;
  assign wrEn = accessCycle && pwrite;
  assign rdEn = setupCycle && !pwrite;

  assign runHit = (paddr == RUN_GATE_OFF);
  assign sleepHit = (paddr == SLEEP_GATE_OFF);
  assign deepHit = (paddr == DEEP_GATE_OFF);
  assign cfgHit = (paddr == RUN_CFG_OFF);
  assign statusHit = (paddr == IRQ_STATUS_OFF);
  assign maskHit = (paddr == IRQ_MASK_OFF);
  assign mappedHit = runHit || sleepHit || deepHit || cfgHit || statusHit || maskHit;

  // ****************************************
  // Write strobes
  // ****************************************
  // Unmapped offsets get no strobe, so such writes are dropped
  assign runWr = wrEn && runHit;
  assign sleepWr = wrEn && sleepHit;
  assign deepWr = wrEn && deepHit;
  assign cfgWr = wrEn && cfgHit;
  assign statusWr = wrEn && statusHit;
  assign maskWr = wrEn && maskHit;

  // ****************************************
  // Write data masking
  // ****************************************
  // Reserved positions never store a one
  assign runGateWr = pwdata & GATE_WRITABLE;
  assign sleepGateWr = pwdata & GATE_WRITABLE;
  assign deepGateWr = pwdata & GATE_WRITABLE;
  assign runCfgWr = pwdata & CFG_WRITABLE;
  assign irqMaskWr = pwdata & IRQ_WRITABLE;
  assign statusClr = pwdata & IRQ_WRITABLE;

  // ****************************************
  // Fault capture
  // ****************************************
  // Access to an unclocked unit flags that unit
  generate
    for (genvar u = 0; u < UNIT_N; u++) begin : g_fault
      assign faultVec[u] = unitAccess[u] && !state_q.clockOn[u];
    end
  endgenerate

  assign faultEvent = |faultVec;

  always_comb begin
    statusSet = 32'h00000000;
    statusSet[IRQ_FAULT_BIT] = faultEvent;
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  // Unmapped offsets read as zero
  always_comb begin
    readMux = 32'h00000000;
    if (runHit) begin
      readMux = state_q.runGate;
    end
    if (sleepHit) begin
      readMux = state_q.sleepGate;
    end
    if (deepHit) begin
      readMux = state_q.deepGate;
    end
    if (cfgHit) begin
      readMux = state_q.runCfg;
    end
    if (statusHit) begin
      readMux = state_q.irqStatus;
    end
    if (maskHit) begin
      readMux = state_q.irqMask;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    state_d.clockOn = activeOn;
    state_d.fault = faultVec;
    if (runWr) begin
      state_d.runGate = runGateWr;
    end
    if (sleepWr) begin
      state_d.sleepGate = sleepGateWr;
    end
    if (deepWr) begin
      state_d.deepGate = deepGateWr;
    end
    if (cfgWr) begin
      state_d.runCfg = runCfgWr;
    end
    if (maskWr) begin
      state_d.irqMask = irqMaskWr;
    end
    if (statusWr) begin
      state_d.irqStatus = state_q.irqStatus & ~statusClr;
    end
    // Set wins over a simultaneous clear
    state_d.irqStatus = state_d.irqStatus | statusSet;
    if (rdEn) begin
      state_d.rdata = readMux;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q.runGate <= GATE_RESET;
      state_q.sleepGate <= GATE_RESET;
      state_q.deepGate <= GATE_RESET;
      state_q.runCfg <= CFG_RESET;
      state_q.irqStatus <= 32'h00000000;
      state_q.irqMask <= 32'h00000000;
      state_q.rdata <= 32'h00000000;
      state_q.clockOn <= '0;
      state_q.fault <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        RUN_GATE_OFF, SLEEP_GATE_OFF, DEEP_GATE_OFF: pslverr = 1'b0;
        RUN_CFG_OFF, IRQ_STATUS_OFF, IRQ_MASK_OFF: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end


  // ****************************************
  // Bus answer
  // ****************************************
  // No wait states; read data comes from the setup-cycle latch
  assign pready = 1'b1;
  assign prdata = state_q.rdata;

  // ****************************************
  // Unit enables
  // ****************************************
  generate
    for (genvar u = 0; u < UNIT_N; u++) begin : g_unit
      assign unitClockOn[u] = state_q.clockOn[u];
      // Exact complement, so no unit is half gated
      assign unitDisable[u] = !state_q.clockOn[u];
      assign unitFault[u] = state_q.fault[u];
    end
  endgenerate

  // ****************************************
  // Interrupt
  // ****************************************
  // Level output, high while an unmasked status bit is set
  assign irqPending = |(state_q.irqStatus & state_q.irqMask);
  assign irq = irqPending;
endmodule
`default_nettype wire

/* design/clock_gate_pkg.sv */
// Purpose: constants for the second run-mode clock gating bank
// Assumes: 32-bit APB, byte addresses
// Notes: one word per register
`default_nettype none
package clock_gate_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] RUN_GATE_OFF = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFF = 12'h128;
  localparam logic [11:0] RUN_CFG_OFF = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h200;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h204;
  localparam int UNIT_N = 9;
  localparam int BIT_PHY = 30;
  localparam int BIT_MAC = 28;
  localparam int BIT_PORT_G = 6;
  localparam logic [31:0] GATE_WRITABLE = 32'h5000007f;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam int BIT_AUTO_GATE = 27;
  localparam logic [31:0] CFG_WRITABLE = 32'h08000000;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_WRITABLE = 32'h00000001;
  localparam int IRQ_FAULT_BIT = 0;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10
  } power_mode_type;
endpackage
`default_nettype wire

/* design/unit_gate_map.sv */
// Purpose: maps a 32-bit gating word onto the unit enables
// Assumes: unit order phy, mac, ports g..a
// Notes: pure combinational
`default_nettype none
module unit_gate_map
  import clock_gate_pkg::*;
(
  input wire logic [31:0] gateWord,
  output logic [clock_gate_pkg::UNIT_N-1:0] unitOn
);
  import clock_gate_pkg::*;
  genvar i;
  // Bit 8 phy, bit 7 mac, bits 6..0 ports g..a
  assign unitOn[UNIT_N-1] = gateWord[BIT_PHY];
  assign unitOn[UNIT_N-2] = gateWord[BIT_MAC];
  generate
    for (i = 0; i <= BIT_PORT_G; i++) begin : g_port
      assign unitOn[i] = gateWord[i];
    end
  endgenerate
endmodule
`default_nettype wire

/* tb/clock_gate_chk.sv */
// Purpose: gating bank checks
// Assumes: top ports only
// Notes: enables lag a run write by two edges
`default_nettype none
module clock_gate_chk
  import clock_gate_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire power_mode_type powerMode,
  input wire logic [UNIT_N-1:0] unitAccess,
  input wire logic [UNIT_N-1:0] unitClockOn,
  input wire logic [UNIT_N-1:0] unitDisable,
  input wire logic [UNIT_N-1:0] unitFault,
  input wire logic irq
);
  // ***
  // Checks
  // ***
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic rd = psel && penable && !pwrite && paddr == RUN_GATE_OFF;
  wire logic wr = psel && penable && pwrite && paddr == RUN_GATE_OFF && powerMode == MODE_RUN;
  chk_disable_inv: assert property (unitDisable == ~unitClockOn) else $error("bad disable");
  chk_fault_pulse: assert property (unitFault == $past(unitAccess & ~unitClockOn))
    else $error("bad fault");
  chk_reset_zero: assert property (disable iff (1'b0) !rst_b |-> unitClockOn == '0 && !irq)
    else $error("bad reset");
  chk_phy_mac: assert property (wr |=> ##1 unitClockOn[8:7] == {$past(pwdata[30], 2),
    $past(pwdata[28], 2)}) else $error("bad phy mac");
  chk_port_map: assert property (wr |=> ##1 unitClockOn[6:0] == $past(pwdata[6:0], 2))
    else $error("bad ports");
  chk_reserved_zero: assert property (rd |-> (prdata & ~GATE_WRITABLE) == '0)
    else $error("bad reserved");
  chk_run_ok: assert property (rd |-> pready && !pslverr) else $error("bad answer");
  chk_unmapped_err: assert property (psel && penable && paddr == 12'h300 |-> pslverr)
    else $error("no error");
  cover property (|unitFault);
  cover property (irq);
  cover property (wr);
endmodule
bind run_mode_clock_gating_2 clock_gate_chk chk (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .powerMode, .unitAccess, .unitClockOn,
  .unitDisable, .unitFault, .irq);
`default_nettype wire

/* tb/testbench.sv */
// Purpose: gating bank bench
// Assumes: APB master, run mode first, then sleep and deep modes
// Notes: rows then faults and modes
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_gate_pkg::*;
  logic clk = 1'b0, rst_b, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  power_mode_type powerMode = MODE_RUN;
  logic [8:0] unitAccess = '0, unitClockOn, unitDisable, unitFault;
  int bad_count = 0, compares = 0, ticks = 0;
  logic [31:0] wv[4] = '{32'hffffffff, 32'h40000001, 32'h10000040, 32'hafffff80};
  logic [31:0] rv[4] = '{32'h5000007f, 32'h40000001, 32'h10000040, 32'h00000000};
  logic [8:0] ov[4] = '{9'h1ff, 9'h101, 9'h0c0, 9'h000};
  always #2.5 clk = ~clk;
  run_mode_clock_gating_2 dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .powerMode, .unitAccess, .unitClockOn, .unitDisable,
    .unitFault, .irq);
  // ***
  // Tasks
  // ***
  task chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      bad_count++;
      summarize;
    end
  end
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    chk("reset on", unitClockOn, 9'h000);
    rst_b <= 1'b1;
    apb(1'b0, RUN_GATE_OFF, '0);
    chk("reset read", rd, GATE_RESET);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, RUN_GATE_OFF, wv[i]);
      settle;
      chk("clock on", unitClockOn, ov[i]);
      apb(1'b0, RUN_GATE_OFF, '0);
      chk("run read", rd, rv[i]);
    end
    $display("rows done");
    unitAccess <= 9'h1ff;
    @(posedge clk);
    unitAccess <= 9'h000;
    #1;
    chk("fault", unitFault, 9'h1ff);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, IRQ_MASK_OFF, 32'h1);
    settle;
    chk("irq set", irq, 1'b1);
    apb(1'b1, IRQ_STATUS_OFF, 32'h1);
    settle;
    chk("irq clear", irq, 1'b0);
    $display("fault done");
    apb(1'b1, RUN_GATE_OFF, 32'h40000000);
    apb(1'b1, SLEEP_GATE_OFF, 32'h1);
    apb(1'b1, DEEP_GATE_OFF, 32'h10000000);
    powerMode <= MODE_SLEEP;
    settle;
    chk("sleep manual", unitClockOn, 9'h100);
    apb(1'b1, RUN_CFG_OFF, 32'h08000000);
    settle;
    chk("sleep auto", unitClockOn, 9'h001);
    @(posedge clk);
    powerMode <= MODE_DEEP;
    settle;
    chk("deep auto", unitClockOn, 9'h080);
    apb(1'b0, 12'h300, '0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped read", rd, 32'h00000000);
    $display("modes done");
    @(posedge clk);
    rst_b <= 1'b0;
    settle;
    chk("mid reset on", unitClockOn, 9'h000);
    chk("mid reset off", unitDisable, 9'h1ff);
    chk("mid reset irq", irq, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, RUN_GATE_OFF, '0);
    chk("mid reset read", rd, GATE_RESET);
    $display("reset done");
    summarize;
  end
endmodule
`default_nettype wire
